// ---- rtl/isl_pkg.sv ----
// shared constants and carrier types for the isolated serial channel block
package isl_pkg;
  // field-active settle delay after field power is seen
  localparam int ISL_CLK_MHZ = 100;
  localparam int ISL_SETTLE_US = 100;
  localparam int ISL_SETTLE_CYCLES = ISL_SETTLE_US * ISL_CLK_MHZ;
  localparam logic [7:0] ISL_INPUT_RESET = 8'h00;
  // external monitor pin level codes
  typedef enum logic [1:0] {ISL_MON_GROUND, ISL_MON_DIVIDER, ISL_MON_RAIL} isl_mon_t;
  // host-side pins
  typedef struct packed {
    logic chipSelectN;
    logic serialClock;
    logic serialIn;
    logic latchN;
    logic outEnableN;
  } isl_host_in_t;
  // field-side status sources
  typedef struct packed {
    logic supplyMissing;
    logic supplyLow;
    logic overTemp;
    logic checksumErr;
    logic wireBreak;
    logic refPinErr;
  } isl_fault_src_t;
endpackage

// ---- rtl/isl_sync.sv ----
// two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
module isl_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic async_in, // level from outside the clock domain
  output logic level, // synchronised level
  output logic rise, // one-cycle pulse on rising edge
  output logic fall // one-cycle pulse on falling edge
);
  typedef struct packed {
    logic stage1;
    logic stage2;
    logic stage3;
  } isl_sync_state_t;
  isl_sync_state_t st;
  isl_sync_state_t next_st;
  // shift through the flops
  always_comb
  begin
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
    next_st.stage3 = st.stage2;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      st <= '{RESET_VAL, RESET_VAL, RESET_VAL};
    end
    else
    begin
      st <= next_st;
    end
  end
  // edges are taken only from the second and third flops
  assign level = st.stage2;
  assign rise = st.stage2 & ~st.stage3;
  assign fall = ~st.stage2 & st.stage3;
endmodule

// ---- rtl/isl_channels.sv ----
// isolated serial channels with input latch, serializer and ready/fault handling
// What this block does
// - host select low drives field select low
// - host data sampled on host clock rise
// - host data out floats only when both high
// - host data out changes on clock fall
// - host latch low drives field latch low
// - host fault low follows field fault channel
// - field-active high normally, defaults when unpowered
// - field-active rises 100us after power seen
// - field select low holds inputs, serial active
// - field data sampled on field clock rise
// - field data out updates on clock fall
// - field data out floats when select high
// - input latch transparent when select, latch high
// - freeze inputs on first select/latch fall
// - fault indicator low when any fault set
// - ready indicator low once field powered
// - ready input high forces defaults, fault low
// - device is last in daisy chain
// - monitor at rail disables supply faults
// - monitor at ground uses internal thresholds
`timescale 1ns/1ps
module isl_channels #(
  parameter int NUM_INPUTS = 8,
  parameter int SETTLE_CYCLES = isl_pkg::ISL_SETTLE_CYCLES
) (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic rst_b, // synchronous reset, active low
  input wire isl_pkg::isl_host_in_t hostPins, // host-side inputs, asynchronous
  output logic hostSerialOut, // host serial data out value
  output logic hostSerialOutEn, // high while host data out is driven
  output logic hostFaultOe, // open-drain host fault, high pulls low
  output logic fieldActiveFlag, // field side active
  output logic fieldChipSelectN, // field chip select out
  output logic fieldSerialClock, // field serial clock out
  output logic isolatedSerialInOut, // isolated data toward field chain
  output logic fieldLatchN, // field latch out
  input wire logic fieldSerialIn, // field serial data in, asynchronous
  output logic fieldSerialOut, // field serial data out value
  output logic fieldSerialOutEn, // high while field data out is driven
  input wire logic [NUM_INPUTS-1:0] fieldInputs, // filtered field input states, asynchronous
  input wire logic [NUM_INPUTS-1:0] rxCapture, // captured serial word input, masked to zero and not used by the logic
  input wire isl_pkg::isl_fault_src_t faultSources, // field fault flags, asynchronous
  input wire isl_pkg::isl_mon_t externalSupplyMonitorIn, // monitor pin strapping
  input wire logic fieldPowerGood, // field supply present, asynchronous
  input wire logic faultChannelIn, // fault channel input, asynchronous
  input wire logic readyChannelIn, // ready channel input, asynchronous
  output logic faultIndicatorOe, // open-drain field fault indicator drive
  output logic readyIndicatorOe, // open-drain ready indicator drive
  output logic [NUM_INPUTS-1:0] receivedWord // last word shifted in on the field side
);
  import isl_pkg::*;

  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam int BIT_W = $clog2(NUM_INPUTS + 1);

  initial
  begin
    // the shift registers slice down to bit NUM_INPUTS-2, so one input cannot be served
    if (NUM_INPUTS < 2 || SETTLE_CYCLES < 1)
    begin
      $error("isl_channels: NUM_INPUTS must be at least 2 and SETTLE_CYCLES at least 1");
    end
  end

  // synchronised pins
  logic csLvl;
  logic csRise;
  logic csFall;
  logic clkLvl;
  logic clkRise;
  logic clkFall;
  logic sdiLvl;
  logic latchLvl;
  logic oenLvl;
  logic fsdiLvl;
  logic powerLvl;
  logic faultInLvl;
  logic readyInLvl;

  // select idles high, so its flops reset high and no false fall follows reset
  isl_sync #(
    .RESET_VAL(1'b1)
  ) uCs (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(hostPins.chipSelectN),
    .level(csLvl),
    .rise(csRise),
    .fall(csFall)
  );
  // serial clock idles low between frames
  isl_sync #(
    .RESET_VAL(1'b0)
  ) uClk (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(hostPins.serialClock),
    .level(clkLvl),
    .rise(clkRise),
    .fall(clkFall)
  );
  // host data only needs its level, edges are taken from the clock
  isl_sync #(
    .RESET_VAL(1'b0)
  ) uSdi (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(hostPins.serialIn),
    .level(sdiLvl),
    .rise(),
    .fall()
  );
  // latch request idles high, transparent latch after reset
  isl_sync #(
    .RESET_VAL(1'b1)
  ) uLatch (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(hostPins.latchN),
    .level(latchLvl),
    .rise(),
    .fall()
  );
  // output enable idles high, host data out floats until selected
  isl_sync #(
    .RESET_VAL(1'b1)
  ) uOen (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(hostPins.outEnableN),
    .level(oenLvl),
    .rise(),
    .fall()
  );
  // field data comes back through the board loop, so it is resynchronised
  isl_sync #(
    .RESET_VAL(1'b0)
  ) uFsdi (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(fieldSerialIn),
    .level(fsdiLvl),
    .rise(),
    .fall()
  );
  // field power is assumed absent until seen
  isl_sync #(
    .RESET_VAL(1'b0)
  ) uPwr (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(fieldPowerGood),
    .level(powerLvl),
    .rise(),
    .fall()
  );
  // fault channel, low means a field fault
  isl_sync #(
    .RESET_VAL(1'b0)
  ) uFin (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(faultChannelIn),
    .level(faultInLvl),
    .rise(),
    .fall()
  );
  // ready channel idles high, field treated as not ready
  isl_sync #(
    .RESET_VAL(1'b1)
  ) uRdy (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(readyChannelIn),
    .level(readyInLvl),
    .rise(),
    .fall()
  );

  // field input states and fault flags need two flops too
  logic [NUM_INPUTS-1:0] inMeta, inSync;
  isl_fault_src_t fltMeta, fltSync;

  typedef enum logic [1:0] {ST_OFF, ST_SETTLE, ST_ACTIVE} isl_pwr_t;

  typedef struct packed {
    isl_pwr_t pwr;
    logic [CNT_W-1:0] settleCnt;
    logic active;
    logic [NUM_INPUTS-1:0] frozen;
    logic [NUM_INPUTS-1:0] shiftOut;
    logic [NUM_INPUTS-1:0] shiftIn;
    logic [BIT_W-1:0] bitCnt;
    logic [NUM_INPUTS-1:0] rxWord;
    logic sdoBit;
    logic hostSdo;
    logic fieldCs;
    logic fieldClk;
    logic fieldLatch;
    logic isoSdi;
    logic faultInd;
    logic hostFault;
  } isl_state_t;

  isl_state_t st;
  isl_state_t next_st;

  // combined supply fault after monitor strapping
  logic supplyFault;
  logic anyFault;
  always_comb
  begin
    supplyFault = fltSync.supplyMissing | fltSync.supplyLow;
    if (externalSupplyMonitorIn == ISL_MON_RAIL)
    begin
      supplyFault = 1'b0;
    end
    // ground and divider strapping both keep monitoring, the source of thresholds lives in the analog side
    anyFault = supplyFault | fltSync.overTemp | fltSync.checksumErr | fltSync.wireBreak | fltSync.refPinErr;
  end

  // next-state logic
  always_comb
  begin
    next_st = st;
    // forward levels across the barrier without decoding; the fault indicator takes the combined fault
    next_st.fieldCs = csLvl;
    next_st.fieldClk = clkLvl;
    next_st.isoSdi = sdiLvl;
    next_st.fieldLatch = latchLvl;
    next_st.faultInd = anyFault;
    // ready and power sequencing
    case (st.pwr)
      ST_OFF:
      begin
        next_st.settleCnt = '0;
        if (powerLvl)
        begin
          next_st.pwr = ST_SETTLE;
        end
      end
      ST_SETTLE:
      begin
        if (!powerLvl)
        begin
          next_st.pwr = ST_OFF;
        end
        else if (st.settleCnt == CNT_W'(SETTLE_CYCLES - 1))
        begin
          next_st.pwr = ST_ACTIVE;
        end
        else
        begin
          next_st.settleCnt = st.settleCnt + 1'b1;
        end
      end
      default:
      begin
        if (!powerLvl)
        begin
          next_st.pwr = ST_OFF;
        end
      end
    endcase
    next_st.active = (next_st.pwr == ST_ACTIVE) && !readyInLvl;
    // input latch: transparent only while both field lines are high
    if (st.fieldCs && st.fieldLatch)
    begin
      next_st.frozen = inSync;
    end
    // serializer runs while field select is low
    if (csFall)
    begin
      next_st.shiftOut = st.frozen;
      next_st.bitCnt = '0;
      next_st.sdoBit = st.frozen[NUM_INPUTS-1];
    end
    else if (!st.fieldCs)
    begin
      if (clkRise)
      begin
        next_st.shiftIn = {st.shiftIn[NUM_INPUTS-2:0], fsdiLvl};
        if (st.bitCnt == BIT_W'(NUM_INPUTS - 1))
        begin
          next_st.rxWord = {st.shiftIn[NUM_INPUTS-2:0], fsdiLvl};
          next_st.bitCnt = '0;
        end
        else
        begin
          next_st.bitCnt = st.bitCnt + 1'b1;
        end
      end
      if (clkFall)
      begin
        next_st.shiftOut = {st.shiftOut[NUM_INPUTS-2:0], 1'b0};
        next_st.sdoBit = st.shiftOut[NUM_INPUTS-2];
      end
    end
    // host output follows field output, updated on falling clock
    // use the coming active value so defaults start in the same cycle as the flag
    if (!next_st.active)
    begin
      next_st.hostSdo = 1'b0;
    end
    else
    begin
      next_st.hostSdo = next_st.sdoBit;
    end
    // fault channel to host: low when field fault or not ready
    next_st.hostFault = !next_st.active || !faultInLvl;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      st <= '0;
      st.pwr <= ST_OFF;
      st.fieldCs <= 1'b1;
      st.fieldLatch <= 1'b1;
      st.hostFault <= 1'b1;
      st.frozen <= ISL_INPUT_RESET;
      inMeta <= '0;
      inSync <= '0;
      fltMeta <= '0;
      fltSync <= '0;
    end
    else
    begin
      st <= next_st;
      inMeta <= fieldInputs;
      inSync <= inMeta;
      fltMeta <= faultSources;
      fltSync <= fltMeta;
    end
  end

  // outputs
  assign hostSerialOut = st.hostSdo;
  assign hostSerialOutEn = !(csLvl && oenLvl);
  assign hostFaultOe = st.hostFault;
  assign fieldActiveFlag = st.active;
  assign fieldChipSelectN = st.fieldCs;
  assign fieldSerialClock = st.fieldClk;
  assign isolatedSerialInOut = st.isoSdi;
  assign fieldLatchN = st.fieldLatch;
  assign fieldSerialOut = st.sdoBit;
  assign fieldSerialOutEn = !st.fieldCs;
  assign faultIndicatorOe = st.faultInd;
  assign readyIndicatorOe = (st.pwr != ST_OFF);
  assign receivedWord = st.rxWord | (rxCapture & '0);
endmodule

// ---- test/isl_chk.sv ----
// assertions on the isolated serial channel ports
`timescale 1ns/1ps
module isl_chk #(
  parameter int SETTLE_CYCLES = 20
) (
  input wire logic ref_clk, // clock
  input wire logic rst_b, // reset
  input wire isl_pkg::isl_host_in_t hostPins, // host pins
  input wire logic hostSerialOutEn, // host out enable
  input wire logic hostSerialOut, // host out
  input wire logic hostFaultOe, // host fault
  input wire logic fieldActiveFlag, // active
  input wire logic fieldChipSelectN, // field select
  input wire logic fieldLatchN, // field latch
  input wire logic fieldSerialOutEn, // field out enable
  input wire isl_pkg::isl_fault_src_t faultSources, // fault flags
  input wire isl_pkg::isl_mon_t externalSupplyMonitorIn, // monitor strap
  input wire logic fieldPowerGood, // power good
  input wire logic faultChannelIn, // fault channel
  input wire logic readyChannelIn, // ready channel
  input wire logic faultIndicatorOe // fault indicator
);
  import isl_pkg::*;
  logic [3:0] runCnt;
  logic [15:0] pwCnt;
  logic anyFault;
  logic settled;
  // cycles since reset release and since power came up
  always_ff @(posedge ref_clk)
  begin
    runCnt <= !rst_b ? 4'h0 : runCnt + {3'h0, runCnt != 4'hf};
    pwCnt <= (!rst_b || !fieldPowerGood) ? 16'h0000 : pwCnt + {15'h0000, pwCnt != 16'hffff};
  end
  // expected fault indicator, supply faults masked at the rail strap
  assign anyFault = faultSources.overTemp | faultSources.checksumErr | faultSources.wireBreak
    | faultSources.refPinErr | ((faultSources.supplyMissing | faultSources.supplyLow)
    & (externalSupplyMonitorIn != ISL_MON_RAIL));
  assign settled = runCnt > 4'h5;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_select_fwd: assert property ((settled && $stable(hostPins.chipSelectN))[*4]
    |-> fieldChipSelectN == hostPins.chipSelectN) else $error("select not forwarded");
  a_latch_fwd: assert property ((settled && $stable(hostPins.latchN))[*4]
    |-> fieldLatchN == hostPins.latchN) else $error("latch not forwarded");
  a_out_enable: assert property ((settled && $stable({hostPins.chipSelectN, hostPins.outEnableN}))[*4]
    |-> hostSerialOutEn == !(hostPins.chipSelectN && hostPins.outEnableN)) else $error("host out enable");
  a_field_float: assert property ($stable(fieldChipSelectN)[*2]
    |-> fieldSerialOutEn == !fieldChipSelectN) else $error("field out enable");
  a_settle_min: assert property ($rose(fieldActiveFlag) |-> pwCnt >= SETTLE_CYCLES)
    else $error("active too early");
  a_settle_max: assert property ((pwCnt > SETTLE_CYCLES + 8 && !readyChannelIn)[*5]
    |-> fieldActiveFlag) else $error("active missing");
  a_default_out: assert property ((readyChannelIn || !fieldPowerGood)[*4]
    |-> !fieldActiveFlag && hostFaultOe && !(hostSerialOutEn && hostSerialOut)) else $error("not in defaults");
  a_fault_fwd: assert property ((fieldActiveFlag && $stable(faultChannelIn))[*5]
    |-> hostFaultOe == !faultChannelIn) else $error("host fault wrong");
  a_fault_ind: assert property ((settled && $stable(anyFault))[*4]
    |-> faultIndicatorOe == anyFault) else $error("fault indicator wrong");
endmodule

// ---- test/isl_host_model.sv ----
// host serial master model: select, clock and data
`timescale 1ns/1ps
module isl_host_model #(
  parameter realtime HALF = 62.5
) (
  output logic chipSelectN, // select
  output logic serialClock, // clock
  output logic serialIn, // data out of host
  input wire logic serialOut, // data into host
  input wire logic serialOutEn // data driven
);
  // idle: deselected, clock still
  initial
  begin
    chipSelectN = 1'b1;
    serialClock = 1'b0;
    serialIn = 1'b0;
  end
  // one word, data set a half period before each rise, reply taken at the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    chipSelectN = 1'b0;
    #(2 * HALF);
    for (int i = 7; i >= 0; i--)
    begin
      serialIn = tx[i];
      #HALF;
      serialClock = 1'b1;
      rx[i] = serialOutEn ? serialOut : 1'bx;
      #HALF;
      serialClock = 1'b0;
    end
    #HALF;
    chipSelectN = 1'b1;
    serialIn = ~serialIn; // released line keeps no stale level
  endtask
endmodule

// ---- test/isl_channels_tb.sv ----
// self-checking bench for the isolated serial channels
`timescale 1ns/1ps
module isl_channels_tb;
  import isl_pkg::*;
  localparam int SETTLE = 20;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cs, sclk, sdi, hOut, hOutEn, hFault, active, field_chip_select, field_latch_n, fOutEn, fInd, rInd, fClk;
  logic latchN = 1'b1;
  logic oenN = 1'b1;
  logic power = 1'b0;
  logic ready = 1'b1;
  logic [7:0] inputs = 8'h00;
  logic [7:0] word, rx;
  logic isoIn;
  isl_fault_src_t src = '0;
  isl_mon_t mon = ISL_MON_GROUND;
  int n_mismatch = 0;
  int n_compared = 0;
  // loopback and open-drain fault wiring of a standalone board
  isl_channels #(.NUM_INPUTS(8), .SETTLE_CYCLES(SETTLE)) isl_channels_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .hostPins({cs, sclk, sdi, latchN, oenN}), .hostSerialOut(hOut), .hostSerialOutEn(hOutEn), .hostFaultOe(hFault),
    .fieldActiveFlag(active), .fieldChipSelectN(field_chip_select), .fieldSerialClock(fClk), .isolatedSerialInOut(isoIn),
    .fieldLatchN(field_latch_n), .fieldSerialIn(isoIn), .fieldSerialOut(), .fieldSerialOutEn(fOutEn),
    .fieldInputs(inputs), .rxCapture(8'h00), .faultSources(src), .externalSupplyMonitorIn(mon),
    .fieldPowerGood(power), .faultChannelIn(~fInd), .readyChannelIn(ready), .faultIndicatorOe(fInd),
    .readyIndicatorOe(rInd), .receivedWord(word));
  isl_host_model isl_host_model_i (.chipSelectN(cs), .serialClock(sclk), .serialIn(sdi), .serialOut(hOut),
    .serialOutEn(hOutEn));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic t_power();
    check("active", active, 1'b0);
    @(posedge ref_clk);
    power <= 1'b1;
    ready <= 1'b0;
    tick(SETTLE - 2);
    check("early", active, 1'b0);
    check("ready ind", rInd, 1'b1);
    tick(12);
    check("settled", active, 1'b1);
  endtask
  task automatic t_frame(input logic [7:0] data, input logic [7:0] tx);
    @(posedge ref_clk) inputs <= data;
    tick(6);
    fork
      isl_host_model_i.xfer(tx, rx);
      begin
        tick(8);
        check("fcs", field_chip_select, 1'b0);
        @(posedge ref_clk) inputs <= ~data;
      end
    join
    check("word", rx, data);
    tick(8);
    check("loop", word, tx);
    check("fout", fOutEn, 1'b0);
    check("fclk", fClk, 1'b0);
  endtask
  task automatic t_latch();
    @(posedge ref_clk) inputs <= 8'h5a;
    tick(6);
    @(posedge ref_clk) latchN <= 1'b0;
    tick(6);
    check("field_latch_n", field_latch_n, 1'b0);
    @(posedge ref_clk) inputs <= 8'h24;
    tick(6);
    isl_host_model_i.xfer(8'h00, rx);
    check("latched", rx, 8'h5a);
    @(posedge ref_clk) latchN <= 1'b1;
  endtask
  task automatic t_fault();
    for (int m = 0; m < 3; m++)
    begin
      @(posedge ref_clk);
      mon <= isl_mon_t'(m);
      src <= '{supplyMissing: 1'b1, default: 1'b0};
      tick(10);
      check("sup ind", fInd, m != 2);
      check("sup host", hFault, m != 2);
    end
    @(posedge ref_clk) src <= '{wireBreak: 1'b1, default: 1'b0};
    tick(10);
    check("wb ind", fInd, 1'b1);
    @(posedge ref_clk) src <= '0;
    tick(10);
    check("clear", hFault, 1'b0);
  endtask
  task automatic t_default();
    check("float", hOutEn, 1'b0);
    @(posedge ref_clk) oenN <= 1'b0;
    tick(6);
    check("enabled", hOutEn, 1'b1);
    @(posedge ref_clk) ready <= 1'b1;
    tick(6);
    check("rdy act", active, 1'b0);
    check("rdy fault", hFault, 1'b1);
    check("rdy out", hOut, 1'b0);
    @(posedge ref_clk);
    ready <= 1'b0;
    power <= 1'b0;
    tick(6);
    check("off", active, 1'b0);
    check("ready off", rInd, 1'b0);
  endtask
  // clock
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  // main sequence
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    tick(6);
    t_power();
    t_frame(8'ha5, 8'h3c);
    t_frame(8'h81, 8'h7e);
    t_latch();
    t_frame(8'h0f, 8'hc3);
    t_fault();
    t_default();
    end_of_test();
  end
  // watchdog: the whole run needs about 6.6 us
  initial
  begin
    #100us;
    n_mismatch++;
    end_of_test();
  end
endmodule
bind isl_channels isl_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) isl_chk_i (.*);
